// [core/frtic_params.svh]
// frtic_params.svh: offsets, field positions, reset values and codes
// of the free-running timer with input capture.
// assumes a 32-bit avalon-mm slave with byte addresses.
`ifndef FRTIC_PARAMS_SVH
`define FRTIC_PARAMS_SVH

`define FRTIC_OFF_CTRL    8'h00
`define FRTIC_OFF_EDGE    8'h04
`define FRTIC_OFF_COUNT   8'h08
`define FRTIC_OFF_STATUS  8'h0c
`define FRTIC_OFF_MASK    8'h10
`define FRTIC_OFF_SVC     8'h14
`define FRTIC_OFF_VECNUM  8'h18
`define FRTIC_OFF_CAP0    8'h20
`define FRTIC_OFF_CAP1    8'h24
`define FRTIC_OFF_CAP2    8'h28
`define FRTIC_OFF_CAP3    8'h2c

`define FRTIC_CTRL_CLR_BIT 2
`define FRTIC_RST_DIVSEL   2'h0
`define FRTIC_RST_EDGE     8'h00
`define FRTIC_RST_FLAGS    5'h00
`define FRTIC_CNT_ZERO     16'h0000
`define FRTIC_CNT_MAX      16'hffff
`define FRTIC_PRE_ZERO     8'h00
`define FRTIC_PRE_STEP     8'h01
`define FRTIC_CNT_STEP     16'h0001

// prescaler terminal counts: divide mclk by 2, 4, 8, 16
`define FRTIC_DIV_TC0 8'h01
`define FRTIC_DIV_TC1 8'h03
`define FRTIC_DIV_TC2 8'h07
`define FRTIC_DIV_TC3 8'h0f

`define FRTIC_EDGE_OFF  2'h0
`define FRTIC_EDGE_RISE 2'h1
`define FRTIC_EDGE_FALL 2'h2
`define FRTIC_EDGE_BOTH 2'h3

`define FRTIC_NUM_OVF  8'h13
`define FRTIC_NUM_CAP0 8'h17
`define FRTIC_NUM_CAP1 8'h19
`define FRTIC_NUM_CAP2 8'h1e
`define FRTIC_NUM_NONE 8'h00
`define FRTIC_VEC_OVF  24'hffffb0
`define FRTIC_VEC_CAP0 24'hffffa0
`define FRTIC_VEC_CAP1 24'hffff98
`define FRTIC_VEC_CAP2 24'hffff84
`define FRTIC_VEC_NONE 24'h000000

`endif

// [core/frtic_pkg.sv]
// frtic_pkg.sv: types shared by the timer top and its capture units.
// assumes nothing beyond a systemverilog compiler.
package frtic_pkg;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } frtic_bus_state_t;

  // result of one two-pin capture unit
  typedef struct packed {
    logic [1:0]       hit;
    logic [1:0][15:0] data;
  } frtic_cap_t;

endpackage

// [core/frtic_capture_unit.sv]
// frtic_capture_unit.sv: one input capture unit serving two pins.
// assumes pins already synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
`include "frtic_params.svh"
module frtic_capture_unit
  import frtic_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // pins and selection
  input  wire logic [1:0]  pin,
  input  wire logic [3:0]  edgeSel,
  // time base
  input  wire logic [15:0] count,
  // result
  output frtic_cap_t       cap
);

  logic [1:0] pinPrev_reg;
  logic       primed_reg;
  frtic_cap_t cap_reg;

  function automatic logic edgeHit(input logic prev, input logic cur,
                                   input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    unique case (sel)
      `FRTIC_EDGE_RISE: edgeHit = rise;
      `FRTIC_EDGE_FALL: edgeHit = fall;
      `FRTIC_EDGE_BOTH: edgeHit = rise | fall;
      `FRTIC_EDGE_OFF:  edgeHit = 1'b0;
    endcase
  endfunction

  // the first sample after reset only primes, so a high pin is no edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinPrev_reg <= 2'h0;
      primed_reg  <= 1'b0;
    end else begin
      pinPrev_reg <= pin;
      primed_reg  <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cap_reg <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cap_reg.hit[i] <= 1'b0;
        if (primed_reg && edgeHit(pinPrev_reg[i], pin[i], edgeSel[2*i +: 2])) begin
          cap_reg.data[i] <= count;
          cap_reg.hit[i]  <= 1'b1;
        end
      end
    end
  end

  assign cap = cap_reg;

endmodule
`default_nettype wire

// [core/frtic_top.sv]
// frtic_top.sv: free-running 16-bit timer with four capture channels,
// avalon-mm register slave, interrupt and io-service requests.
// assumes capture pins synchronous to mclk and a master that holds
// its request until waitrequest is sampled low.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "frtic_params.svh"
module frtic_top
  import frtic_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // capture pins
  input  wire logic [3:0]  capPin,
  // interrupt requests
  output logic             irq,
  output logic [3:0]       irqLine,
  output logic [7:0]       intNum,
  output logic [23:0]      intVec,
  // intelligent io service
  output logic [4:0]       ioSvcReq,
  input  wire logic [4:0]  ioSvcAck
);

  frtic_bus_state_t busState_reg;
  logic             waitReq_reg;
  logic [31:0]      readData_reg;

  logic [1:0]       divSel_reg;
  logic [7:0]       edgeSel_reg;
  logic [4:0]       mask_reg;
  logic [4:0]       svcEn_reg;
  logic [4:0]       status_reg;
  logic [4:0]       status_next;

  logic [7:0]       prescale_reg;
  logic [15:0]      count_reg;

  logic             irq_reg;
  logic [3:0]       irqLine_reg;
  logic [7:0]       intNum_reg;
  logic [23:0]      intVec_reg;
  logic [4:0]       ioSvcReq_reg;

  logic             busReq;
  logic             access;
  logic             wrAcc;
  logic             rdAcc;
  logic [7:0]       addrOff;
  logic             tick;
  logic             clrCnt;
  logic             ovfEvt;
  logic [4:0]       events;
  logic [4:0]       rdClear;
  logic [4:0]       pending;
  frtic_cap_t       capLo;
  frtic_cap_t       capHi;
  logic [3:0][15:0] capData;

  // prescaler terminal count for the selected ratio
  function automatic logic [7:0] divTc(input logic [1:0] sel);
    unique case (sel)
      2'h0: divTc = `FRTIC_DIV_TC0;
      2'h1: divTc = `FRTIC_DIV_TC1;
      2'h2: divTc = `FRTIC_DIV_TC2;
      2'h3: divTc = `FRTIC_DIV_TC3;
    endcase
  endfunction

  // write of the selected register with byte lane 0 enabled
  function automatic logic wrLow(input logic acc, input logic [7:0] off,
                                 input logic [7:0] reg_off, input logic be0);
    wrLow = acc && (off == reg_off) && be0;
  endfunction

  assign busReq  = avs_read | avs_write;
  assign addrOff = {avs_address[7:2], 2'h0};
  assign access  = (busState_reg == BUS_ACK) && busReq;
  assign wrAcc   = access && avs_write;
  assign rdAcc   = access && avs_read;

  // bus handshake: every access answers on the second edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      busState_reg <= BUS_IDLE;
    end else begin
      unique case (busState_reg)
        BUS_IDLE: begin
          if (busReq) begin
            busState_reg <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          busState_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      waitReq_reg <= 1'b1;
    end else begin
      waitReq_reg <= !((busState_reg == BUS_IDLE) && busReq);
    end
  end

  // read data are latched one edge before the access edge and stand there
  always_ff @(posedge mclk) begin
    if (srst) begin
      readData_reg <= 32'h0;
    end else if ((busState_reg == BUS_IDLE) && avs_read) begin
      unique case (addrOff)
        `FRTIC_OFF_CTRL:   readData_reg <= {30'h0, divSel_reg};
        `FRTIC_OFF_EDGE:   readData_reg <= {24'h0, edgeSel_reg};
        `FRTIC_OFF_COUNT:  readData_reg <= {16'h0, count_reg};
        `FRTIC_OFF_STATUS: readData_reg <= {27'h0, status_reg};
        `FRTIC_OFF_MASK:   readData_reg <= {27'h0, mask_reg};
        `FRTIC_OFF_SVC:    readData_reg <= {27'h0, svcEn_reg};
        `FRTIC_OFF_VECNUM: readData_reg <= {intVec_reg, intNum_reg};
        `FRTIC_OFF_CAP0:   readData_reg <= {16'h0, capData[0]};
        `FRTIC_OFF_CAP1:   readData_reg <= {16'h0, capData[1]};
        `FRTIC_OFF_CAP2:   readData_reg <= {16'h0, capData[2]};
        `FRTIC_OFF_CAP3:   readData_reg <= {16'h0, capData[3]};
        default:           readData_reg <= 32'h0;
      endcase
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      divSel_reg <= `FRTIC_RST_DIVSEL;
    end else if (wrLow(wrAcc, addrOff, `FRTIC_OFF_CTRL, avs_byteenable[0])) begin
      divSel_reg <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      edgeSel_reg <= `FRTIC_RST_EDGE;
    end else if (wrLow(wrAcc, addrOff, `FRTIC_OFF_EDGE, avs_byteenable[0])) begin
      edgeSel_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_reg <= `FRTIC_RST_FLAGS;
    end else if (wrLow(wrAcc, addrOff, `FRTIC_OFF_MASK, avs_byteenable[0])) begin
      mask_reg <= avs_writedata[4:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      svcEn_reg <= `FRTIC_RST_FLAGS;
    end else if (wrLow(wrAcc, addrOff, `FRTIC_OFF_SVC, avs_byteenable[0])) begin
      svcEn_reg <= avs_writedata[4:0];
    end
  end

  // prescaler and free-running counter
  assign clrCnt = wrLow(wrAcc, addrOff, `FRTIC_OFF_CTRL, avs_byteenable[0])
                  && avs_writedata[`FRTIC_CTRL_CLR_BIT];
  assign tick   = (prescale_reg == divTc(divSel_reg));
  assign ovfEvt = tick && (count_reg == `FRTIC_CNT_MAX) && !clrCnt;

  // a ratio change mid-period takes effect at once against the running count,
  // so a smaller ratio may run one long period first
  always_ff @(posedge mclk) begin
    if (srst || clrCnt || tick) begin
      prescale_reg <= `FRTIC_PRE_ZERO;
    end else begin
      prescale_reg <= prescale_reg + `FRTIC_PRE_STEP;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || clrCnt) begin
      count_reg <= `FRTIC_CNT_ZERO;
    end else if (tick) begin
      count_reg <= count_reg + `FRTIC_CNT_STEP;
    end
  end

  // two capture units share the counter
  frtic_capture_unit u_capLo (
    .mclk    (mclk),
    .srst    (srst),
    .pin     (capPin[1:0]),
    .edgeSel (edgeSel_reg[3:0]),
    .count   (count_reg),
    .cap     (capLo)
  );

  frtic_capture_unit u_capHi (
    .mclk    (mclk),
    .srst    (srst),
    .pin     (capPin[3:2]),
    .edgeSel (edgeSel_reg[7:4]),
    .count   (count_reg),
    .cap     (capHi)
  );

  assign capData = {capHi.data, capLo.data};

  // status: bit0 overflow, bits 1..4 capture channels 0..3
  assign events = {capHi.hit, capLo.hit, ovfEvt};

  // only bits the read actually returned are cleared, so an event that
  // lands between the data latch and the access edge is kept
  assign rdClear = (rdAcc && (addrOff == `FRTIC_OFF_STATUS)) ? readData_reg[4:0] : 5'h0;

  // set wins over clear for every source
  assign status_next = (status_reg & ~(rdClear | (ioSvcAck & svcEn_reg))) | events;

  always_ff @(posedge mclk) begin
    if (srst) begin
      status_reg <= `FRTIC_RST_FLAGS;
    end else begin
      status_reg <= status_next;
    end
  end

  // sources routed to the io service do not disturb the processor
  assign pending = status_reg & mask_reg & ~svcEn_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_reg      <= 1'b0;
      irqLine_reg  <= 4'h0;
      ioSvcReq_reg <= 5'h0;
    end else begin
      irq_reg        <= |pending;
      irqLine_reg[0] <= pending[0];
      irqLine_reg[1] <= pending[1];
      irqLine_reg[2] <= pending[2];
      irqLine_reg[3] <= pending[3] | pending[4];
      ioSvcReq_reg   <= status_reg & svcEn_reg;
    end
  end

  // highest-priority pending request: lower number wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      intNum_reg <= `FRTIC_NUM_NONE;
      intVec_reg <= `FRTIC_VEC_NONE;
    end else if (pending[0]) begin
      intNum_reg <= `FRTIC_NUM_OVF;
      intVec_reg <= `FRTIC_VEC_OVF;
    end else if (pending[1]) begin
      intNum_reg <= `FRTIC_NUM_CAP0;
      intVec_reg <= `FRTIC_VEC_CAP0;
    end else if (pending[2]) begin
      intNum_reg <= `FRTIC_NUM_CAP1;
      intVec_reg <= `FRTIC_VEC_CAP1;
    end else if (pending[3] || pending[4]) begin
      intNum_reg <= `FRTIC_NUM_CAP2;
      intVec_reg <= `FRTIC_VEC_CAP2;
    end else begin
      intNum_reg <= `FRTIC_NUM_NONE;
      intVec_reg <= `FRTIC_VEC_NONE;
    end
  end

  assign avs_readdata    = readData_reg;
  assign avs_waitrequest = waitReq_reg;
  assign irq             = irq_reg;
  assign irqLine         = irqLine_reg;
  assign intNum          = intNum_reg;
  assign intVec          = intVec_reg;
  assign ioSvcReq        = ioSvcReq_reg;

endmodule
`default_nettype wire

// [verif/frtic_checker_sva.sv]
// frtic_checker_sva.sv: port-level assertions for frtic_top.
// assumes it is bound to frtic_top and sees one mclk domain.
`timescale 1ns/100ps
`default_nettype none
`include "frtic_params.svh"
module frtic_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // interrupts and service
  input wire logic        irq,
  input wire logic [3:0]  irqLine,
  input wire logic [7:0]  intNum,
  input wire logic [23:0] intVec,
  input wire logic [4:0]  ioSvcReq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_bound: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("request not answered");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_irq_sum: assert property (irq == (irqLine != 4'h0))
    else $error("irq disagrees with irq lines");
  a_ovf_number: assert property (irqLine[0] && ioSvcReq == 5'h00 |-> intNum == `FRTIC_NUM_OVF && intVec == `FRTIC_VEC_OVF)
    else $error("overflow number or vector wrong");
  a_cap0_number: assert property (irqLine[1:0] == 2'h2 && ioSvcReq == 5'h00 |-> intNum == `FRTIC_NUM_CAP0)
    else $error("capture 0 number wrong");
  a_cap23_number: assert property (irqLine == 4'h8 && ioSvcReq == 5'h00 |-> intNum == `FRTIC_NUM_CAP2)
    else $error("capture 2/3 number wrong");
  a_svc_excl: assert property ((ioSvcReq[2:0] & irqLine[2:0]) == 3'h0)
    else $error("source on both irq and io service");
  a_ovf_sticky: assert property ($fell(irqLine[0]) |-> $past(avs_read || avs_write, 2))
    else $error("overflow request dropped without software");

  c_cap0_irq: cover property (irqLine[1] && intNum == `FRTIC_NUM_CAP0);
  c_cap23_irq: cover property (irqLine[3]);
  c_svc_req: cover property (ioSvcReq[1]);
endmodule
`default_nettype wire

// [verif/frtic_pin_src.sv]
// frtic_pin_src.sv: external source driving the four capture pins.
// assumes the bench sets wanted levels just after a rising mclk edge.
`timescale 1ns/100ps
`default_nettype none
module frtic_pin_src (
  // clock and reset
  input wire logic       mclk,
  input wire logic       srst,
  // levels
  input wire logic [3:0] want,
  output logic [3:0]     capPin
);
  // registered so pin changes stay synchronous to mclk, as the block expects
  always_ff @(posedge mclk) begin
    if (srst) begin
      capPin <= 4'h0;
    end else begin
      capPin <= want;
    end
  end
endmodule
`default_nettype wire

// [verif/test_free_run_timer_input_capture.sv]
// test_free_run_timer_input_capture.sv: register-level tests of frtic_top.
// assumes frtic_checker and frtic_pin_src are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "frtic_params.svh"
module test_free_run_timer_input_capture;
  import frtic_pkg::*;
  logic        mclk, srst, avsRead, avsWrite, irq;
  logic [7:0]  avsAddress, intNum;
  logic [31:0] avsWritedata, avsReaddata, rd, c0, c1;
  logic [3:0]  avsByteenable, capWant, capPin, irqLine;
  logic        avsWaitrequest;
  logic [23:0] intVec;
  logic [4:0]  ioSvcReq, ioSvcAck;
  int          failCount, testsRun, cycles;
  logic [7:0]  offs [0:10] = '{`FRTIC_OFF_CTRL, `FRTIC_OFF_EDGE, `FRTIC_OFF_STATUS, `FRTIC_OFF_MASK,
    `FRTIC_OFF_SVC, `FRTIC_OFF_VECNUM, `FRTIC_OFF_CAP0, `FRTIC_OFF_CAP1, `FRTIC_OFF_CAP2, `FRTIC_OFF_CAP3, 8'h30};

  frtic_top u_frtic_top (.mclk(mclk), .srst(srst), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .capPin(capPin), .irq(irq),
    .irqLine(irqLine), .intNum(intNum), .intVec(intVec), .ioSvcReq(ioSvcReq), .ioSvcAck(ioSvcAck));
  frtic_pin_src u_frtic_pin_src (.mclk(mclk), .srst(srst), .want(capWant), .capPin(capPin));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    @(posedge mclk);
    while (avsWaitrequest !== 1'b0) @(posedge mclk);
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic busRd(input logic [7:0] a, output logic [31:0] d);
    avsAddress <= a;
    avsRead <= 1'b1;
    @(posedge mclk);
    while (avsWaitrequest !== 1'b0) @(posedge mclk);
    d = avsReaddata;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  // pin change, then enough cycles for status and irq to settle
  task automatic pinSet(input logic [3:0] v);
    capWant <= v;
    tick(6);
  endtask

  task automatic completeRun();
    $display("checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      completeRun();
    end
  end

  initial begin
    srst = 1'b1;
    {avsRead, avsWrite, avsAddress, avsWritedata, capWant, ioSvcAck} = '0;
    avsByteenable = 4'hf;
    tick(5);
    srst <= 1'b0;
    tick(1);
    busWr(`FRTIC_OFF_CAP0, 32'h1234);
    busWr(8'h30, 32'h55);
    for (int i = 0; i < 11; i++) begin
      busRd(offs[i], rd);
      chk("reset value", 32'h0, rd);
    end
    $display("test reset values done");
    busWr(`FRTIC_OFF_CTRL, 32'h7);
    busRd(`FRTIC_OFF_COUNT, rd);
    chk("count after clear", 32'h0, rd);
    busWr(`FRTIC_OFF_EDGE, 32'h05);
    for (int r = 0; r < 4; r++) begin
      busWr(`FRTIC_OFF_CTRL, 32'h4 | r);
      pinSet(4'h0);
      pinSet(4'h1);
      tick(58);
      pinSet(4'h3);
      busRd(`FRTIC_OFF_CAP0, c0);
      busRd(`FRTIC_OFF_CAP1, c1);
      chk("capture spacing", 32'(64 >> (r + 1)), {16'h0, c1[15:0] - c0[15:0]});
      pinSet(4'h0);
      busRd(`FRTIC_OFF_CAP1, rd);
      chk("capture hold", c1, rd);
    end
    busRd(`FRTIC_OFF_STATUS, rd);
    $display("test ratios done");
    busWr(`FRTIC_OFF_EDGE, 32'h39);
    pinSet(4'hf);
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("rising hits", 32'h0a, rd);
    pinSet(4'h0);
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("falling hits", 32'h0c, rd);
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("status cleared", 32'h0, rd);
    $display("test edges done");
    busWr(`FRTIC_OFF_EDGE, 32'h33);
    busWr(`FRTIC_OFF_MASK, 32'h0a);
    pinSet(4'h1);
    chk("irq", 32'h1, {31'h0, irq});
    chk("irq lines", 32'h2, {28'h0, irqLine});
    chk("vector", 32'hffffa017, {intVec, intNum});
    busRd(`FRTIC_OFF_VECNUM, rd);
    chk("vecnum reg", 32'hffffa017, rd);
    pinSet(4'h5);
    chk("shared line", 32'ha, {28'h0, irqLine});
    chk("priority", 32'h17, {24'h0, intNum});
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("status", 32'h0a, rd);
    tick(3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    busWr(`FRTIC_OFF_MASK, 32'h0);
    pinSet(4'h4);
    chk("masked irq", 32'h0, {31'h0, irq});
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("masked status", 32'h02, rd);
    $display("test interrupts done");
    busWr(`FRTIC_OFF_MASK, 32'h2);
    busWr(`FRTIC_OFF_SVC, 32'h2);
    pinSet(4'h5);
    chk("svc request", 32'h2, {27'h0, ioSvcReq});
    chk("no irq on svc", 32'h0, {31'h0, irq});
    ioSvcAck <= 5'h02;
    tick(1);
    ioSvcAck <= 5'h00;
    tick(3);
    chk("svc acked", 32'h0, {27'h0, ioSvcReq});
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("svc status", 32'h0, rd);
    $display("test io service done");
    // channel 1 and channel 3 each alone, so every capture number and vector is seen
    busWr(`FRTIC_OFF_SVC, 32'h0);
    busWr(`FRTIC_OFF_EDGE, 32'hff);
    busWr(`FRTIC_OFF_MASK, 32'h1c);
    pinSet(4'h7);
    chk("cap1 vector", 32'hffff9819, {intVec, intNum});
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("cap1 status", 32'h04, rd);
    tick(3);
    pinSet(4'hf);
    chk("cap3 line", 32'h8, {28'h0, irqLine});
    chk("cap3 vector", 32'hffff841e, {intVec, intNum});
    busRd(`FRTIC_OFF_STATUS, rd);
    chk("cap3 status", 32'h10, rd);
    $display("test channel numbers done");
    completeRun();
  end
endmodule

bind frtic_top frtic_checker u_frtic_checker (.mclk(mclk), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
  .irqLine(irqLine), .intNum(intNum), .intVec(intVec), .ioSvcReq(ioSvcReq));
`default_nettype wire
